// [hdl/ps2cr_channel.sv]
// PS/2 channel with Wishbone register set, receiver and transmitter
// Functional notes
// - Writing the transmit byte launches a serial send of that byte.
// - Every received byte that passes its parity and stop checks lands in the read-only receive byte at offset zero.
// - A send waits while unread receive data is pending.
// - Receive byte reads FFh after reset and is reloaded with FFh after each read.
// - Stop field 5:4 chooses expected stop level: high, low or ignored.
// - Parity field 3:2 chooses odd, even or ignored parity check.
// - Stop and parity choices act only while the channel is enabled.
// - Channel disabled: clock line driven low, data line released.
// - Channel enabled: receive or transmit automatically per direction bit.
// - Direction bit 0 selects receive at 0, transmit at 1; resets to 0.
// - Received byte sets ready and holds clock low until the byte is read.
// - Send ends on eleventh clock edge, clearing direction and returning idle.
// - Transmit writes ignored when disabled, receiving, or already transmitting.
// - Frame is start, eight data bits LSB first, parity, stop; peer clocks.
//
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/10ps
module ps2cr_channel
	import ps2cr_pkg::*;
#(
	parameter int ADR_W = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [ADR_W-1:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	output logic irq_o,
	input wire logic serial_clock_line_i,
	output logic serial_clock_line_o,
	output logic serial_clock_line_oe_o,
	input wire logic serial_data_line_i,
	output logic serial_data_line_o,
	output logic serial_data_line_oe_o
);
	if (ADR_W < 8) begin : g_chk
		$error("ps2cr_channel: ADR_W must be at least 8");
	end

	ps2cr_core_if cif ();

	ps2cr_sync u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.bus(cif.syncer)
	);

	ps2cr_irq u_irq (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.bus(cif.irqs)
	);

	logic ack_reg;
	logic [31:0] dat_reg;
	logic [CTRL_W-1:0] ctrl_reg;
	logic [7:0] rx_byte_reg;
	logic rx_ready_reg;
	logic [3:0] rx_cnt_reg;
	logic [7:0] rx_sh_reg;
	logic rx_par_reg;
	ps2cr_tx_t tx_state_reg;
	logic [9:0] tx_sh_reg;
	logic tx_bit_reg;
	logic [3:0] tx_cnt_reg;
	logic scl_prev_reg;
	logic scl_oe_reg;
	logic sda_oe_reg;

	logic scl_s;
	logic sda_s;
	logic fall;
	logic en;
	logic dir;
	logic [1:0] par_mode;
	logic [1:0] stop_mode;
	logic acc;
	logic wr;
	logic rd;
	logic [7:0] off;
	logic tx_wr;
	logic rd_data;
	logic ctrl_wr;
	logic rx_active;
	logic rx_end;
	logic par_ok;
	logic stop_ok;
	logic rx_load;
	logic rx_err;
	logic tx_done;
	logic scl_oe_next;
	logic sda_oe_next;

	assign cif.pin_raw[PIN_CLK] = serial_clock_line_i;
	assign cif.pin_raw[PIN_DAT] = serial_data_line_i;
	assign scl_s = cif.pin_sync[PIN_CLK];
	assign sda_s = cif.pin_sync[PIN_DAT];
	// The peer owns the clock; its falling edge paces every bit
	assign fall = scl_prev_reg & ~scl_s;

	assign en = ctrl_reg[CTRL_EN_BIT];
	assign dir = ctrl_reg[CTRL_DIR_BIT];
	assign par_mode = ctrl_reg[CTRL_PAR_LSB +: 2];
	assign stop_mode = ctrl_reg[CTRL_STOP_LSB +: 2];

	// Bus access takes effect on the edge where the master sees ack
	assign off = adr_i[7:0];
	assign acc = cyc_i & stb_i & ack_reg;
	assign wr = acc & we_i & sel_i[0];
	assign rd = acc & ~we_i;
	assign ctrl_wr = wr & (off == OFF_CTRL);
	assign rd_data = rd & (off == OFF_DATA);
	assign tx_wr = wr & (off == OFF_DATA) & en & dir & (tx_state_reg == TXS_IDLE);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			scl_prev_reg <= 1'b1;
		end else begin
			scl_prev_reg <= scl_s;
		end
	end

	// Wishbone slave: one wait state, unmapped offsets read zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= cyc_i & stb_i & ~ack_reg;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_reg <= '0;
		end else if (cyc_i & stb_i & ~ack_reg) begin
			dat_reg <= '0;
			case (off)
				OFF_DATA: dat_reg[7:0] <= rx_load ? rx_sh_reg : rx_byte_reg;
				OFF_CTRL: dat_reg[CTRL_W-1:0] <= ctrl_reg;
				OFF_STAT: begin
					dat_reg[ST_RX_READY] <= rx_ready_reg;
					dat_reg[ST_TX_IDLE] <= tx_state_reg != TXS_SEND;
					dat_reg[ST_RX_BUSY] <= rx_cnt_reg != 4'h0;
					dat_reg[ST_TX_HOLD] <= tx_state_reg == TXS_HOLD;
				end
				OFF_ISTAT: dat_reg[EV_W-1:0] <= cif.stat | cif.ev;
				OFF_IMASK: dat_reg[EV_W-1:0] <= cif.mask;
				default: dat_reg <= '0;
			endcase
		end
	end

	// direction bit, cleared by hardware at the end of a send
	// Software writing control in that same cycle takes precedence
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_reg <= CTRL_RESET;
		end else if (ctrl_wr) begin
			ctrl_reg <= dat_i[CTRL_W-1:0];
		end else if (tx_done) begin
			ctrl_reg[CTRL_DIR_BIT] <= 1'b0;
		end
	end

	// receiver runs only when enabled and direction selects receive
	assign rx_active = en & ~dir & ~rx_ready_reg;
	assign rx_end = rx_active & fall & (rx_cnt_reg == RX_STOP_EDGE);

	// parity check selection, reserved code treated as ignore
	always_comb begin
		case (par_mode)
			PAR_ODD: par_ok = ^{rx_sh_reg, rx_par_reg};
			PAR_EVEN: par_ok = ~^{rx_sh_reg, rx_par_reg};
			default: par_ok = 1'b1;
		endcase
	end

	// stop level selection, reserved code treated as ignore
	always_comb begin
		case (stop_mode)
			STOP_HIGH: stop_ok = sda_s;
			STOP_LOW: stop_ok = ~sda_s;
			default: stop_ok = 1'b1;
		endcase
	end

	// checks only matter on an enabled frame end
	assign rx_load = rx_end & par_ok & stop_ok;
	assign rx_err = rx_end & ~(par_ok & stop_ok);

	// frame shift, start then data LSB first, parity, stop
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_cnt_reg <= 4'h0;
			rx_sh_reg <= 8'h00;
			rx_par_reg <= 1'b0;
		end else if (~en | dir) begin
			// Leaving receive abandons a partial frame
			rx_cnt_reg <= 4'h0;
		end else if (rx_active & fall) begin
			if (rx_cnt_reg == 4'h0) begin
				// A high start bit is noise; keep waiting
				rx_cnt_reg <= sda_s ? 4'h0 : 4'h1;
			end else if (rx_cnt_reg == RX_STOP_EDGE) begin
				rx_cnt_reg <= 4'h0;
			end else begin
				rx_cnt_reg <= rx_cnt_reg + 4'h1;
				if (rx_cnt_reg == RX_PARITY_EDGE) begin
					rx_par_reg <= sda_s;
				end else begin
					rx_sh_reg <= {sda_s, rx_sh_reg[7:1]};
				end
			end
		end
	end

	// receive byte load; FFh after read, new byte wins
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_byte_reg <= RX_RESET;
		end else if (rx_load) begin
			rx_byte_reg <= rx_sh_reg;
		end else if (rd_data) begin
			rx_byte_reg <= RX_RESET;
		end
	end

	// ready flag set on a good frame, cleared by reading the byte
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_ready_reg <= 1'b0;
		end else if (rx_load) begin
			rx_ready_reg <= 1'b1;
		end else if (rd_data) begin
			rx_ready_reg <= 1'b0;
		end
	end

	assign tx_done = (tx_state_reg == TXS_SEND) & fall & (tx_cnt_reg == FRAME_EDGES - 4'h1);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_state_reg <= TXS_IDLE;
			tx_sh_reg <= {2'b11, TX_RESET};
			tx_bit_reg <= 1'b1;
			tx_cnt_reg <= 4'h0;
		end else if (~en | ~dir) begin
			tx_state_reg <= TXS_IDLE;
			tx_bit_reg <= 1'b1;
		end else begin
			case (tx_state_reg)
				TXS_IDLE: begin
					if (tx_wr) begin
						// Stop, odd parity, then data shifted out LSB first
						tx_sh_reg <= {1'b1, ~^dat_i[7:0], dat_i[7:0]};
						tx_state_reg <= TXS_HOLD;
					end
				end
				TXS_HOLD: begin
					// wait for unread data to go
					if (~rx_ready_reg) begin
						tx_state_reg <= TXS_SEND;
						tx_bit_reg <= 1'b0;
						tx_cnt_reg <= 4'h0;
					end
				end
				TXS_SEND: begin
					if (tx_done) begin
						tx_state_reg <= TXS_IDLE;
						tx_bit_reg <= 1'b1;
					end else if (fall) begin
						tx_bit_reg <= tx_sh_reg[0];
						tx_sh_reg <= {1'b1, tx_sh_reg[9:1]};
						tx_cnt_reg <= tx_cnt_reg + 4'h1;
					end
				end
				default: tx_state_reg <= TXS_IDLE;
			endcase
		end
	end

	// disabled drives clock low; ready holds clock low
	always_comb begin
		if (~en) begin
			scl_oe_next = 1'b1;
			sda_oe_next = 1'b0;
		end else if (dir) begin
			// Armed or holding: inhibit the peer until the send starts
			scl_oe_next = tx_state_reg != TXS_SEND;
			sda_oe_next = (tx_state_reg == TXS_SEND) & ~tx_bit_reg;
		end else begin
			scl_oe_next = rx_ready_reg;
			sda_oe_next = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			scl_oe_reg <= 1'b1;
			sda_oe_reg <= 1'b0;
		end else begin
			scl_oe_reg <= scl_oe_next;
			sda_oe_reg <= sda_oe_next;
		end
	end

	assign cif.ev[EV_RX_DONE] = rx_load;
	assign cif.ev[EV_TX_DONE] = tx_done;
	assign cif.ev[EV_RX_ERR] = rx_err;
	assign cif.stat_clr = rd & (off == OFF_ISTAT);
	assign cif.mask_we = wr & (off == OFF_IMASK);
	assign cif.mask_wdata = dat_i[EV_W-1:0];

	assign dat_o = dat_reg;
	assign ack_o = ack_reg;
	assign irq_o = cif.irq;
	// Open drain: only ever pull low
	assign serial_clock_line_o = 1'b0;
	assign serial_clock_line_oe_o = scl_oe_reg;
	assign serial_data_line_o = 1'b0;
	assign serial_data_line_oe_o = sda_oe_reg;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	chk_tx_launch_start: assert property (
		tx_wr |=> tx_state_reg == TXS_HOLD ##[1:40] tx_state_reg == TXS_SEND || rx_ready_reg)
		else $error("transmit write did not launch a send");
	chk_rx_byte_load: assert property (
		rx_load |=> rx_ready_reg && rx_byte_reg == $past(rx_sh_reg))
		else $error("received byte not stored");
	chk_tx_hold_off: assert property (
		tx_state_reg == TXS_HOLD && rx_ready_reg && en && dir |=> tx_state_reg != TXS_SEND)
		else $error("send started over unread data");
	chk_rx_reload_ff: assert property (
		rd_data && !rx_load |=> rx_byte_reg == RX_RESET && !rx_ready_reg)
		else $error("receive byte not reloaded after read");
	chk_disabled_pins: assert property (
		!en |=> scl_oe_reg && !sda_oe_reg)
		else $error("disabled channel pins wrong");
	chk_ready_clock_low: assert property (
		rx_ready_reg && en && !dir ##1 rx_ready_reg |-> scl_oe_reg)
		else $error("clock not held low with data pending");
	chk_tx_end_clear: assert property (
		tx_done && !ctrl_wr |=> tx_state_reg == TXS_IDLE && !dir ##1 !sda_oe_reg)
		else $error("send end did not clear direction");
	chk_tx_write_block: assert property (
		wr && off == OFF_DATA && tx_state_reg == TXS_IDLE && (!en || !dir)
		|=> tx_state_reg == TXS_IDLE)
		else $error("blocked transmit write took effect");
	chk_frame_count: assert property (
		rx_cnt_reg <= RX_STOP_EDGE && tx_cnt_reg < FRAME_EDGES)
		else $error("frame bit counter out of range");
	chk_rsv_zero: assert property (
		ack_reg |-> dat_reg[31:8] == 24'h000000)
		else $error("reserved read bits not zero");
endmodule // ps2cr_channel

// [hdl/ps2cr_pkg.sv]
// Constants, field layouts and types of the PS/2 channel register block
package ps2cr_pkg;
	// Byte offsets on the register bus
	localparam logic [7:0] OFF_DATA = 8'h00;
	localparam logic [7:0] OFF_CTRL = 8'h04;
	localparam logic [7:0] OFF_STAT = 8'h08;
	localparam logic [7:0] OFF_ISTAT = 8'h0c;
	localparam logic [7:0] OFF_IMASK = 8'h10;
	// Control register layout
	localparam int CTRL_W = 6;
	localparam int CTRL_DIR_BIT = 0;
	localparam int CTRL_EN_BIT = 1;
	localparam int CTRL_PAR_LSB = 2;
	localparam int CTRL_STOP_LSB = 4;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;
	// Stop level and parity selections
	localparam logic [1:0] STOP_HIGH = 2'h0;
	localparam logic [1:0] STOP_LOW = 2'h1;
	localparam logic [1:0] PAR_ODD = 2'h0;
	localparam logic [1:0] PAR_EVEN = 2'h1;
	// Data register values after reset
	localparam logic [7:0] RX_RESET = 8'hff;
	localparam logic [7:0] TX_RESET = 8'h00;
	// Frame layout: edge counts within an eleven-bit frame
	localparam logic [3:0] FRAME_EDGES = 4'hb;
	localparam logic [3:0] RX_PARITY_EDGE = 4'h9;
	localparam logic [3:0] RX_STOP_EDGE = 4'ha;
	// Status register layout
	localparam int ST_RX_READY = 0;
	localparam int ST_TX_IDLE = 1;
	localparam int ST_RX_BUSY = 2;
	localparam int ST_TX_HOLD = 3;
	// Interrupt event bits, same layout in status and mask
	localparam int EV_W = 3;
	localparam int EV_RX_DONE = 0;
	localparam int EV_TX_DONE = 1;
	localparam int EV_RX_ERR = 2;
	localparam logic [EV_W-1:0] IMASK_RESET = 3'h0;
	// Pin index in the synchroniser
	localparam int PIN_CLK = 0;
	localparam int PIN_DAT = 1;
	localparam int PIN_W = 2;

	typedef enum logic [1:0] {TXS_IDLE, TXS_HOLD, TXS_SEND} ps2cr_tx_t;
endpackage

// [hdl/ps2cr_core_if.sv]
// Carrier between the channel core, its pin synchroniser and its interrupt unit
`timescale 1ns/10ps
interface ps2cr_core_if;
	import ps2cr_pkg::*;
	logic [PIN_W-1:0] pin_raw;
	logic [PIN_W-1:0] pin_sync;
	logic [EV_W-1:0] ev;
	logic stat_clr;
	logic mask_we;
	logic [EV_W-1:0] mask_wdata;
	logic [EV_W-1:0] stat;
	logic [EV_W-1:0] mask;
	logic irq;
	modport syncer (input pin_raw, output pin_sync);
	modport irqs (input ev, stat_clr, mask_we, mask_wdata, output stat, mask, irq);
	modport core (output pin_raw, ev, stat_clr, mask_we, mask_wdata,
		input pin_sync, stat, mask, irq);
endinterface

// [hdl/ps2cr_sync.sv]
// Two-flop synchronisers for the serial clock and data pins
`timescale 1ns/10ps
module ps2cr_sync
	import ps2cr_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	ps2cr_core_if.syncer bus
);
	logic [PIN_W-1:0] meta_reg;
	logic [PIN_W-1:0] sync_reg;

	// Idle lines are pulled high, so reset to the released level
	for (genvar i = 0; i < PIN_W; i++) begin : g_pin
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				meta_reg[i] <= 1'b1;
				sync_reg[i] <= 1'b1;
			end else begin
				meta_reg[i] <= bus.pin_raw[i];
				sync_reg[i] <= meta_reg[i];
			end
		end
	end

	assign bus.pin_sync = sync_reg;
endmodule // ps2cr_sync

// [hdl/ps2cr_irq.sv]
// Sticky event status, mask and level interrupt of the channel
`timescale 1ns/10ps
module ps2cr_irq
	import ps2cr_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	ps2cr_core_if.irqs bus
);
	logic [EV_W-1:0] stat_reg;
	logic [EV_W-1:0] mask_reg;
	logic irq_reg;
	logic [EV_W-1:0] stat_next;

	// An event in the clearing cycle survives the read
	assign stat_next = (bus.stat_clr ? '0 : stat_reg) | bus.ev;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stat_reg <= '0;
		end else begin
			stat_reg <= stat_next;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mask_reg <= IMASK_RESET;
		end else if (bus.mask_we) begin
			mask_reg <= bus.mask_wdata;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= |(stat_next & mask_reg);
		end
	end

	assign bus.stat = stat_reg;
	assign bus.mask = mask_reg;
	assign bus.irq = irq_reg;
endmodule // ps2cr_irq

// [sim/ps2cr_peer.sv]
// Behavioural PS/2 keyboard or mouse on the far side of the channel
`timescale 1ns/10ps
module ps2cr_peer (
	input wire logic clk_line_i,
	input wire logic dat_line_i,
	output logic clk_low_o,
	output logic dat_low_o
);
	initial begin
		clk_low_o = 1'b0;
		dat_low_o = 1'b0;
	end
	// peer clocks a frame, LSB first
	task automatic send(input logic [10:0] f);
		wait (clk_line_i === 1'b1);
		for (int i = 0; i < 11; i++) begin
			dat_low_o = ~f[i];
			#200 clk_low_o = 1'b1;
			#400 clk_low_o = 1'b0;
			#200;
		end
		// Released data floats up to the pull-up level
		dat_low_o = 1'b0;
	endtask
	// host bits sampled before each falling edge
	task automatic recv(output logic [10:0] f);
		wait (dat_line_i === 1'b0 && clk_line_i === 1'b1);
		for (int i = 0; i < 11; i++) begin
			#400 f[i] = dat_line_i;
			clk_low_o = 1'b1;
			#400 clk_low_o = 1'b0;
		end
	endtask
endmodule // ps2cr_peer

// [sim/testbench.sv]
// Self-checking bench of the PS/2 channel register block
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; \
	$display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module testbench;
	import ps2cr_pkg::*;
	logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, irq_o, sc_oe, sd_oe, p_clk, p_dat;
	logic sc_o, sd_o;
	logic [7:0] adr_i;
	logic [3:0] sel_i;
	logic [31:0] dat_i, dat_o, q;
	logic [10:0] f;
	logic [7:0] d, t;
	logic [1:0] pc, sc;
	logic [2:0] m;
	logic p, s, ok;
	int fail_count, checks, cyc_n;
	// Open-drain lines with pull-ups
	wire clk_w = ~((sc_oe & ~sc_o) | p_clk);
	wire dat_w = ~((sd_oe & ~sd_o) | p_dat);

	ps2cr_channel uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
		.we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
		.ack_o(ack_o), .irq_o(irq_o), .serial_clock_line_i(clk_w),
		.serial_clock_line_o(sc_o), .serial_clock_line_oe_o(sc_oe),
		.serial_data_line_i(dat_w), .serial_data_line_o(sd_o),
		.serial_data_line_oe_o(sd_oe));
	ps2cr_peer peer (.clk_line_i(clk_w), .dat_line_i(dat_w), .clk_low_o(p_clk),
		.dat_low_o(p_dat));

	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	task close_out;
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	always @(posedge clk_i) begin
		cyc_n++;
		if (cyc_n == 20000) begin
			fail_count++;
			close_out();
		end
	end

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
		input logic [3:0] sl, output logic [31:0] rd);
		int n;
		n = 0;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= wd;
		sel_i <= sl;
		@(posedge clk_i);
		while (ack_o !== 1'b1 && n < 50) begin
			@(posedge clk_i);
			n++;
		end
		rd = dat_o;
		`CHK("bus ack", 1'b1, ack_o)
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] wd);
		logic [31:0] x;
		bus(1'b1, a, wd, 4'hf, x);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
		bus(1'b0, a, 32'h0, 4'hf, q);
		`CHK(nm, e, q)
	endtask
	// control changes kept 500 ns apart
	task automatic ctl(input logic [31:0] wd);
		wr(OFF_CTRL, wd);
		repeat (5) @(posedge clk_i);
	endtask
	// stop and parity checks chosen by control
	function automatic logic rx_ok(input logic [1:0] pc, sc, input logic [7:0] d,
		input logic p, s);
		return (pc[1] || ((^{d, p}) == ~pc[0])) && (sc[1] || (s == ~sc[0]));
	endfunction

	initial begin
		rst_i = 1'b1;
		{cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = '0;
		fail_count = 0;
		checks = 0;
		cyc_n = 0;
		void'($urandom(32'hde79));
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rdc(OFF_DATA, 32'hff, "receive reset");
		rdc(OFF_CTRL, 32'h0, "control reset");
		`CHK("clock low off", 1'b1, sc_oe)
		`CHK("data float off", 1'b0, sd_oe)
		bus(1'b1, OFF_CTRL, 32'h3f, 4'he, q);
		rdc(OFF_CTRL, 32'h0, "lane gated");
		ctl(32'hffffffe6);
		rdc(OFF_CTRL, 32'h26, "reserved zero");
		ctl(32'h0);
		wr(OFF_DATA, 32'h3c);
		repeat (20) @(posedge clk_i);
		`CHK("tx off ignored", 1'b0, sd_oe)
		rdc(8'h20, 32'h0, "unmapped");
		for (int i = 0; i < 8; i++) begin
			d = $urandom;
			pc = $urandom_range(2);
			sc = $urandom_range(2);
			p = ^d ^ ~pc[0];
			s = ~sc[0];
			if ($urandom_range(3) == 0) p = ~p;
			if ($urandom_range(3) == 0) s = ~s;
			m = i[0] ? 3'h0 : 3'h5;
			wr(OFF_IMASK, {29'h0, m});
			ctl({26'h0, sc, pc, 2'b10});
			peer.send({s, p, d, 1'b0});
			repeat (8) @(posedge clk_i);
			ok = rx_ok(pc, sc, d, p, s);
			`CHK("clock hold", ok, sc_oe)
			`CHK("irq level", m != 3'h0, irq_o)
			rdc(OFF_ISTAT, ok ? 32'h1 : 32'h4, "events");
			rdc(OFF_DATA, ok ? {24'h0, d} : 32'hff, "receive byte");
			rdc(OFF_DATA, 32'hff, "receive reload");
			`CHK("clock release", 1'b0, sc_oe)
			`CHK("irq clear", 1'b0, irq_o)
		end
		ctl(32'h2);
		wr(OFF_DATA, 32'h5a);
		repeat (20) @(posedge clk_i);
		`CHK("tx rx ignored", 1'b0, sd_oe)
		d = $urandom;
		peer.send({1'b1, ~^d, d, 1'b0});
		for (int k = 0; k < 2; k++) begin
			ctl(32'h3);
			t = $urandom;
			wr(OFF_DATA, {24'h0, t});
			repeat (20) @(posedge clk_i);
			if (k == 0) begin
				`CHK("tx held", 1'b0, sd_oe)
				rdc(OFF_STAT, 32'hb, "held status");
				rdc(OFF_DATA, {24'h0, d}, "pending byte");
			end
			peer.recv(f);
			`CHK("tx frame", {1'b1, ~^t, t, 1'b0}, f)
			repeat (8) @(posedge clk_i);
			rdc(OFF_CTRL, 32'h2, "dir cleared");
			rdc(OFF_ISTAT, k == 0 ? 32'h3 : 32'h2, "tx events");
		end
		ctl(32'h0);
		`CHK("disabled clock", 1'b1, sc_oe)
		close_out();
	end
endmodule // testbench
